/* File: rtl/btc_counters.sv */
// BCD time and calendar counters with rate trimming, behind an 8-bit register port.
// Assumes the serial front end delivers one-cycle read/write strobes on clk,
// and that osc_tick and osc_halt_flag are synchronous to clk.
`timescale 1ns/1ns
module btc_counters
    import btc_pkg::*;
#(
    parameter int unsigned DIV = SEC_DIV
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         nrst,
    // Crystal tick and status
    input  wire logic         osc_tick,
    input  wire logic         osc_halt_flag,
    input  wire logic         mode_24h,
    // Register port
    input  wire btc_reg_req_t req,
    output logic [7:0]        rdata,
    // Outputs
    output logic              clk32_tick_out,
    output logic              sec_tick
);

    // BCD increment of a two-digit value
    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        if (v[3:0] == 4'h9)
            return {v[7:4] + 4'h1, 4'h0};
        else
            return {v[7:4], v[3:0] + 4'h1};
    endfunction : bcd_inc

    function automatic logic is_leap(input logic [7:0] y);
        if (y[4] == 1'b0)
            return (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
        else
            return (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
    endfunction : is_leap

    // last day of the month, leap February
    function automatic logic [7:0] last_day(input logic [7:0] m, input logic leap);
        case (m)
            8'h02:                         return leap ? DAYS_29 : DAYS_28;
            8'h04, 8'h06, 8'h09, 8'h11:    return DAYS_30;
            default:                       return DAYS_31;
        endcase
    endfunction : last_day

    // signed length change from the trim field
    function automatic logic signed [8:0] trim_adj(input logic [7:0] t);
        logic signed [8:0] v;
        v = 9'(signed'(t[6:0]));
        if (t[5:1] == 5'h00)
            return 9'sh000;
        else if (t[TRIM_SIGN_BIT])
            return 9'(v * 2);
        else
            return 9'((v - 9'sh001) * 2);
    endfunction : trim_adj

    // Counter registers
    logic [7:0] second;
    logic [7:0] minute;
    logic [7:0] hour_count;
    logic [2:0] weekday_count;
    logic [7:0] day_of_month_count;
    logic [7:0] month_and_century;
    logic [7:0] year_count;
    logic [7:0] rate_trim;
    logic       trim_armed;
    logic       halt_prev;

    // Next values
    logic [7:0] next_second;
    logic [7:0] next_minute;
    logic [7:0] next_hour;
    logic [2:0] next_weekday;
    logic [7:0] next_day;
    logic [7:0] next_month;
    logic [7:0] next_year;

    // Carries and decodes
    logic         min_carry;
    logic         hour_carry;
    logic         day_carry;
    logic         month_carry;
    logic         year_carry;
    logic         leap;
    logic         halt_rise;
    logic         wr_sec;
    logic         wr_trim;
    logic         trim_wr_ok;
    logic [7:0]   sec_after;
    logic         trim_point;
    btc_div_ctl_t div_ctl;
    logic [7:0]   read_mux;
    logic [7:0]   hour12_inc;

    // Write strobes for the seconds and trim registers
    assign wr_sec     = req.wr && (req.addr == OFS_SECOND);
    assign wr_trim    = req.wr && (req.addr == OFS_TRIM);
    // locked write when top bit is set
    assign trim_wr_ok = wr_trim && !req.wdata[TRIM_LOCK_BIT];
    assign halt_rise  = osc_halt_flag && !halt_prev;
    assign leap       = is_leap(year_count);

    assign next_second = (second == BCD_59) ? BCD_00 : bcd_inc(second);
    assign min_carry   = sec_tick && (second == BCD_59);
    assign next_minute = (minute == BCD_59) ? BCD_00 : bcd_inc(minute);
    assign hour_carry  = min_carry && (minute == BCD_59);

    // Twelve-hour digits stepped without the PM flag
    assign hour12_inc = bcd_inc({3'b000, hour_count[4:0]});

    // hour step and day carry in both modes
    always_comb begin
        next_hour = hour_count;
        day_carry = 1'b0;
        if (mode_24h) begin
            if (hour_count == BCD_23) begin
                next_hour = BCD_00;
                day_carry = hour_carry;
            end else begin
                next_hour = bcd_inc(hour_count);
            end
        end else begin
            // midnight is 12, noon is 32, D5 flags PM
            case (hour_count)
                BCD_12:    next_hour = BCD_01;
                HR12_AM11: next_hour = HR12_PM12;
                HR12_PM12: next_hour = HR12_PM01;
                HR12_PM11: begin
                    next_hour = BCD_12;
                    day_carry = hour_carry;
                end
                default:   next_hour = {2'b00, hour_count[HOUR_PM_BIT], hour12_inc[4:0]};
            endcase
        end
    end

    assign next_weekday = (weekday_count == WDAY_LAST) ? 3'h0 : weekday_count + 3'h1;

    // day back to 1 past the last day
    assign next_day    = (day_of_month_count == last_day({3'b000, month_and_century[4:0]}, leap))
                         ? BCD_01 : bcd_inc(day_of_month_count);
    assign month_carry = day_carry
                         && (day_of_month_count == last_day({3'b000, month_and_century[4:0]}, leap));

    // month wraps 12 to 1 with year carry
    assign next_month  = (month_and_century[4:0] == BCD_12[4:0]) ? BCD_01
                         : bcd_inc({3'b000, month_and_century[4:0]});
    assign year_carry  = month_carry && (month_and_century[4:0] == BCD_12[4:0]);
    assign next_year   = (year_count == BCD_99) ? BCD_00 : bcd_inc(year_count);

    // Seconds value that the coming period starts with
    assign sec_after  = wr_sec ? (req.wdata & MASK_SECOND) : next_second;
    // trim points at 00, 20 and 40
    assign trim_point = (sec_after == BCD_00) || (sec_after == BCD_20) || (sec_after == BCD_40);

    // a seconds write restarts the divider
    assign div_ctl.restart = wr_sec;
    // a trim write in this cycle suppresses the trim
    assign div_ctl.adj     = (trim_armed && trim_point && !wr_trim && !halt_rise)
                             ? trim_adj(rate_trim) : 9'sh000;

    // divider of crystal ticks per second
    btc_sec_divider #(
        .DIV      (DIV)
    ) u_div (
        .clk      (clk),
        .nrst     (nrst),
        .osc_tick (osc_tick),
        .ctl      (div_ctl),
        .sec_tick (sec_tick)
    );

    // crystal copy bypasses the trimmed divider
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst)
            clk32_tick_out <= 1'b0;
        else
            clk32_tick_out <= osc_tick;
    end

    // Time counters; a host write beats a carry in the same cycle
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            second <= RST_SECOND;
            minute <= RST_MINUTE;
            hour_count <= RST_HOUR;
        end else begin
            // masked writes keep unused bits at zero
            if (wr_sec)
                second <= req.wdata & MASK_SECOND;
            else if (sec_tick)
                second <= next_second;
            if (req.wr && req.addr == OFS_MINUTE)
                minute <= req.wdata & MASK_MINUTE;
            else if (min_carry)
                minute <= next_minute;
            if (req.wr && req.addr == OFS_HOUR)
                hour_count <= req.wdata & MASK_HOUR;
            else if (hour_carry)
                hour_count <= next_hour;
        end
    end

    // Calendar counters
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            weekday_count <= RST_WEEKDAY[2:0];
            day_of_month_count <= RST_DAY;
            month_and_century <= RST_MONTH;
            year_count <= RST_YEAR;
        end else begin
            if (req.wr && req.addr == OFS_WEEKDAY)
                weekday_count <= req.wdata[2:0];
            else if (day_carry)
                weekday_count <= next_weekday;
            if (req.wr && req.addr == OFS_DAY)
                day_of_month_count <= req.wdata & MASK_DAY;
            else if (day_carry)
                day_of_month_count <= next_day;
            if (req.wr && req.addr == OFS_MONTH)
                month_and_century <= req.wdata & MASK_MONTH;
            else if (year_carry && year_count == BCD_99)
                month_and_century <= {~month_and_century[CENTURY_BIT], next_month[6:0]};
            else if (month_carry)
                month_and_century <= {month_and_century[CENTURY_BIT], next_month[6:0]};
            if (req.wr && req.addr == OFS_YEAR)
                year_count <= req.wdata;
            else if (year_carry)
                year_count <= next_year;
        end
    end

    // Trim register; halt clear wins over a host write in the same cycle
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rate_trim  <= RST_TRIM;
            trim_armed <= 1'b0;
            halt_prev  <= 1'b0;
        end else begin
            halt_prev <= osc_halt_flag;
            // halt clears the whole trim register
            if (halt_rise) begin
                rate_trim  <= RST_TRIM;
                trim_armed <= 1'b0;
            // writing the trim bits arms trimming
            end else if (trim_wr_ok) begin
                rate_trim  <= req.wdata & MASK_TRIM;
                trim_armed <= 1'b1;
            end
        end
    end

    // Read selection; unmapped offsets read zero
    always_comb begin
        case (req.addr)
            OFS_SECOND:  read_mux = second;
            OFS_MINUTE:  read_mux = minute;
            OFS_HOUR:    read_mux = hour_count;
            OFS_WEEKDAY: read_mux = {5'h00, weekday_count};
            OFS_DAY:     read_mux = day_of_month_count;
            OFS_MONTH:   read_mux = month_and_century;
            OFS_YEAR:    read_mux = year_count;
            OFS_TRIM:    read_mux = rate_trim;
            default:     read_mux = 8'h00;
        endcase
    end

    // Read data held until the next read strobe
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst)
            rdata <= 8'h00;
        else if (req.rd)
            rdata <= read_mux;
    end

endmodule : btc_counters

/* File: include/btc_pkg.sv */
// Package for the BCD time and calendar counter block.
// Assumes a single 20 MHz clock and a one-cycle crystal tick enable.
package btc_pkg;

    // Clock and crystal rates
    localparam int unsigned CLK_HZ      = 20_000_000;
    localparam int unsigned XTAL_HZ     = 32_768;
    localparam int unsigned SEC_DIV     = 32768;   // crystal ticks per untrimmed second

    // Register offsets
    localparam logic [3:0] OFS_SECOND   = 4'h0;
    localparam logic [3:0] OFS_MINUTE   = 4'h1;
    localparam logic [3:0] OFS_HOUR     = 4'h2;
    localparam logic [3:0] OFS_WEEKDAY  = 4'h3;
    localparam logic [3:0] OFS_DAY      = 4'h4;
    localparam logic [3:0] OFS_MONTH    = 4'h5;
    localparam logic [3:0] OFS_YEAR     = 4'h6;
    localparam logic [3:0] OFS_TRIM     = 4'h7;

    // Implemented-bit masks per register
    localparam logic [7:0] MASK_SECOND  = 8'h7f;
    localparam logic [7:0] MASK_MINUTE  = 8'h7f;
    localparam logic [7:0] MASK_HOUR    = 8'h3f;
    localparam logic [7:0] MASK_WEEKDAY = 8'h07;
    localparam logic [7:0] MASK_DAY     = 8'h3f;
    localparam logic [7:0] MASK_MONTH   = 8'h9f;
    localparam logic [7:0] MASK_TRIM    = 8'h7f;

    // Field positions
    localparam int unsigned HOUR_PM_BIT   = 5;   // hour_tens_twenty / PM flag
    localparam int unsigned CENTURY_BIT   = 7;
    localparam int unsigned TRIM_LOCK_BIT = 7;
    localparam int unsigned TRIM_SIGN_BIT = 6;

    // Reset values
    localparam logic [7:0] RST_SECOND   = 8'h00;
    localparam logic [7:0] RST_MINUTE   = 8'h00;
    localparam logic [7:0] RST_HOUR     = 8'h00;
    localparam logic [7:0] RST_WEEKDAY  = 8'h00;
    localparam logic [7:0] RST_DAY      = 8'h01;
    localparam logic [7:0] RST_MONTH    = 8'h01;
    localparam logic [7:0] RST_YEAR     = 8'h00;
    localparam logic [7:0] RST_TRIM     = 8'h00;

    // BCD limits and special codes
    localparam logic [7:0] BCD_59       = 8'h59;
    localparam logic [7:0] BCD_23       = 8'h23;
    localparam logic [7:0] BCD_99       = 8'h99;
    localparam logic [7:0] BCD_12       = 8'h12;
    localparam logic [7:0] BCD_01       = 8'h01;
    localparam logic [7:0] BCD_00       = 8'h00;
    localparam logic [7:0] BCD_20       = 8'h20;
    localparam logic [7:0] BCD_40       = 8'h40;
    localparam logic [7:0] HR12_AM11    = 8'h11;
    localparam logic [7:0] HR12_PM12    = 8'h32;
    localparam logic [7:0] HR12_PM01    = 8'h21;
    localparam logic [7:0] HR12_PM11    = 8'h31;
    localparam logic [2:0] WDAY_LAST    = 3'h6;
    localparam logic [7:0] DAYS_31      = 8'h31;
    localparam logic [7:0] DAYS_30      = 8'h30;
    localparam logic [7:0] DAYS_29      = 8'h29;
    localparam logic [7:0] DAYS_28      = 8'h28;

    // Register access request from the serial front end
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [3:0] addr;
        logic [7:0] wdata;
    } btc_reg_req_t;

    // Divider length control, sampled at each period start
    typedef struct packed {
        logic              restart;
        logic signed [8:0] adj;
    } btc_div_ctl_t;

endpackage : btc_pkg

/* File: rtl/btc_sec_divider.sv */
// One-second divider driven by crystal tick enables, with per-period length adjust.
// Assumes osc_tick is a one-cycle pulse per crystal cycle, synchronous to clk.
`timescale 1ns/1ns
module btc_sec_divider
    import btc_pkg::*;
#(
    parameter int unsigned DIV = SEC_DIV
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         nrst,
    // Crystal tick and control
    input  wire logic         osc_tick,
    input  wire btc_div_ctl_t ctl,
    // Second carry
    output logic              sec_tick
);
    logic [16:0] cnt;
    logic [16:0] last;       // terminal count of the running period
    logic [16:0] next_last;
    logic        at_end;

    // Period end and the length of the period that follows it
    assign at_end    = osc_tick && (cnt == last);
    assign sec_tick  = at_end && !ctl.restart;
    assign next_last = 17'(DIV - 1) + 17'(ctl.adj);

    // Counter; a restart wins over a tick so the new second starts clean
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt  <= 17'h00000;
            last <= 17'(DIV - 1);
        end else if (ctl.restart || at_end) begin
            cnt  <= 17'h00000;
            last <= next_last;
        end else if (osc_tick) begin
            cnt  <= cnt + 17'h00001;
        end
    end

endmodule : btc_sec_divider

/* File: bench/btc_host_model.sv */
// Host model for the counter register port: one-cycle read and write strobes.
// Assumes the device samples strobes on the rising clk edge.
`timescale 1ns/1ns
module btc_host_model
    import btc_pkg::*;
(
    // Clock
    input  wire logic       clk,
    // Register port
    input  wire logic [7:0] rdata,
    output btc_reg_req_t    req
);
    // Idle bus: inverted address and data, so stale values never look valid
    initial req = '{wr: 1'b0, rd: 1'b0, addr: 4'hf, wdata: 8'h00};

    task automatic idle();
        req.wr = 1'b0;
        req.rd = 1'b0;
        req.addr = ~req.addr;
        req.wdata = ~req.wdata;
    endtask : idle

    task automatic wr(input logic [3:0] addr, input logic [7:0] data);
        @(posedge clk);
        #1;
        req = '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
        @(posedge clk);
        #1;
        idle();
    endtask : wr

    // Read data is settled by the same edge that takes the strobe
    task automatic rd(input logic [3:0] addr, output logic [7:0] data);
        @(posedge clk);
        #1;
        req = '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: req.wdata};
        @(posedge clk);
        #1;
        idle();
        data = rdata;
    endtask : rd
endmodule : btc_host_model

/* File: bench/btc_counters_checker.sv */
// Port assertions for the BCD time and calendar counters.
// Assumes the bind below hands on the divider length DIV.
`timescale 1ns/1ns
module btc_counters_checker
    import btc_pkg::*;
#(
    parameter int unsigned DIV = SEC_DIV
) (
    // Clock and reset
    input wire logic         clk,
    input wire logic         nrst,
    // Inputs
    input wire logic         osc_tick,
    input wire logic         osc_halt_flag,
    input wire logic         mode_24h,
    input wire btc_reg_req_t req,
    // Outputs
    input wire logic [7:0]   rdata,
    input wire logic         clk32_tick_out,
    input wire logic         sec_tick
);
    localparam int LO = DIV - 130;
    localparam int HI = DIV + 124;
    int unsigned cnt;
    logic        armed;
    wire         sec_wr = req.wr && req.addr == OFS_SECOND;

    // Ticks since period start; armed stays set, trimmed lengths only bounded
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt <= 0;
            armed <= 1'b0;
        end else begin
            if (sec_wr || sec_tick) cnt <= 0;
            else if (osc_tick) cnt <= cnt + 1;
            if (req.wr && req.addr == OFS_TRIM && req.wdata[5:1] != 5'h00) armed <= 1'b1;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    untrimmed_period_a: assert property (sec_tick && !armed |-> cnt == DIV - 1)
        else $error("untrimmed second has wrong length");
    tick_window_a: assert property (sec_tick |-> osc_tick && cnt >= LO)
        else $error("second ended too early");
    second_bound_a: assert property (cnt <= HI)
        else $error("second carry missing");
    clock_copy_a: assert property (osc_tick |=> clk32_tick_out)
        else $error("crystal copy lost a pulse");
    unmapped_zero_a: assert property (req.rd && req.addr > OFS_TRIM |=> rdata == 8'h00)
        else $error("unmapped read not zero");
    hour_upper_a: assert property (req.rd && req.addr == OFS_HOUR |=> rdata[7:6] == 2'b00)
        else $error("hour upper bits set");
    weekday_range_a: assert property (req.rd && req.addr == OFS_WEEKDAY |=> rdata <= {5'h00, WDAY_LAST})
        else $error("weekday out of range");
    month_range_a: assert property (req.rd && req.addr == OFS_MONTH |=>
        rdata[6:5] == 2'b00 && rdata[4:0] >= 5'h01 && rdata[4:0] <= 5'h12)
        else $error("month out of range");
    halt_clears_a: assert property ($rose(osc_halt_flag) ##1 (req.rd && req.addr == OFS_TRIM) |=> rdata == 8'h00)
        else $error("trim not cleared by halt");
    read_hold_a: assert property (!req.rd |=> $stable(rdata))
        else $error("read data changed without a read");
    hour_range_a: assert property (req.rd && req.addr == OFS_HOUR && mode_24h |=> rdata <= BCD_23)
        else $error("24-hour value out of range");

    cover property (sec_tick && armed);
    cover property ($rose(osc_halt_flag));
    cover property (req.rd && req.addr > OFS_TRIM);
endmodule : btc_counters_checker

bind btc_counters btc_counters_checker #(.DIV(DIV)) i_chk (.clk(clk), .nrst(nrst), .osc_tick(osc_tick),
    .osc_halt_flag(osc_halt_flag), .mode_24h(mode_24h), .req(req), .rdata(rdata),
    .clk32_tick_out(clk32_tick_out), .sec_tick(sec_tick));

/* File: bench/btc_counters_bench.sv */
// Self-checking bench for the BCD time and calendar counters.
// Assumes a shortened divider and a crystal tick every second clk cycle.
`timescale 1ns/1ns
module btc_counters_bench
    import btc_pkg::*;
;
    localparam int unsigned DIV = 256;
    logic         clk = 1'b0;
    logic         nrst = 1'b0;
    logic         osc_tick = 1'b0;
    logic         osc_halt_flag = 1'b0;
    logic         mode_24h = 1'b1;
    btc_reg_req_t req;
    logic [7:0]   rdata;
    logic         sec_tick;
    logic [7:0]   v;
    int           n_errors = 0;
    int           n_compared = 0;
    int           p;
    // Rows: second, minute, hour, weekday, day, month, year; last two in 12-hour mode
    logic [55:0]  rin [11] = '{56'h59592306311299, 56'h59592302280223, 56'h59592303280224,
        56'h59592304290224, 56'h59592301300423, 56'h59592301300123, 56'h59592301280200,
        56'h59592305319299, 56'h5959d9f9150623, 56'h59593105150623, 56'h59591105150623};
    logic [55:0]  rex [11] = '{56'h00000000018100, 56'h00000003010323, 56'h00000004290224,
        56'h00000005010324, 56'h00000002010523, 56'h00000002310123, 56'h00000002290200,
        56'h00000006010100, 56'h00002001150623, 56'h00001206160623, 56'h00003205150623};
    logic [7:0]   trims [5] = '{8'h07, 8'h7e, 8'h01, 8'h41, 8'h42};
    logic [7:0]   secs [3] = '{8'h19, 8'h39, 8'h59};

    btc_counters #(.DIV(DIV)) i_dut (.clk(clk), .nrst(nrst), .osc_tick(osc_tick), .osc_halt_flag(osc_halt_flag),
        .mode_24h(mode_24h), .req(req), .rdata(rdata), .clk32_tick_out(), .sec_tick(sec_tick));
    btc_host_model i_host (.clk(clk), .rdata(rdata), .req(req));

    // 50 ns clock; crystal tick pulses on every other cycle
    initial begin
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        #1 osc_tick = ~osc_tick;
    end

    task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk8

    task automatic chki(input string name, input int exp, input int got);
        n_compared++;
        if (got != exp) begin
            n_errors++;
            $display("[FAIL] %s expected %0d seen %0d", name, exp, got);
        end
    endtask : chki

    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : print_verdict

    // Waits for the next second carry, counting crystal ticks on the way
    task automatic wait_sec(output int ticks);
        int i;
        ticks = 0;
        for (i = 0; i < 4 * DIV + 600; i++) begin
            @(posedge clk);
            #2;
            ticks += int'(osc_tick === 1'b1);
            if (sec_tick === 1'b1) break;
        end
        if (sec_tick !== 1'b1) begin
            n_errors++;
            $display("[FAIL] second carry expected 1 seen %b", sec_tick);
            print_verdict();
        end
    endtask : wait_sec

    // Expected period change, worked out independently of the design
    function automatic int trim_adj(input logic [6:0] t);
        if (t[5:1] == 5'h00) return 0;
        if (!t[6]) return 2 * (int'(t[5:0]) - 1);
        return 2 * (int'(t[5:0]) - 64);
    endfunction : trim_adj

    initial begin
        repeat (8) @(posedge clk);
        #1 nrst = 1'b1;
        for (int a = 0; a < 10; a++) begin
            i_host.rd(a[3:0], v);
            chk8("reset value", (a < 8) ? 8'(64'h0000000001010000 >> (8 * (7 - a))) : 8'h00, v);
        end
        $display("reset test done");
        for (int r = 0; r < 11; r++) begin
            mode_24h = (r < 9);
            for (int a = 6; a >= 0; a--) i_host.wr(a[3:0], rin[r][8*(6-a)+:8]);
            wait_sec(p);
            for (int a = 0; a < 7; a++) begin
                i_host.rd(a[3:0], v);
                chk8("rollover", rex[r][8*(6-a)+:8], v);
            end
        end
        $display("rollover test done");
        for (int r = 0; r < 5; r++) begin
            i_host.wr(OFS_TRIM, trims[r]);
            i_host.wr(OFS_SECOND, secs[r % 3]);
            wait_sec(p);
            wait_sec(p);
            chki("trimmed period", DIV + trim_adj(trims[r][6:0]), p);
            wait_sec(p);
            chki("next period", DIV, p);
        end
        i_host.wr(OFS_TRIM, 8'h85);
        i_host.rd(OFS_TRIM, v);
        chk8("locked trim write", 8'h42, v);
        $display("trim test done");
        @(posedge clk);
        #1 osc_halt_flag = 1'b1;
        i_host.rd(OFS_TRIM, v);
        chk8("trim after halt", 8'h00, v);
        i_host.wr(OFS_SECOND, 8'h19);
        wait_sec(p);
        wait_sec(p);
        chki("period after halt", DIV, p);
        @(posedge clk);
        #1 osc_halt_flag = 1'b0;
        $display("halt test done");
        repeat (DIV) @(posedge clk);
        i_host.wr(OFS_SECOND, 8'h05);
        wait_sec(p);
        chki("restarted second", DIV, p);
        i_host.rd(OFS_SECOND, v);
        chk8("second after restart", 8'h06, v);
        $display("restart test done");
        print_verdict();
    end
endmodule : btc_counters_bench
